// [hdl/abcr_pkg.sv]
// Constants, types and carriers shared by the acquisition/balance configuration registers
package abcr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int              ADDR_W        = 8;
  localparam int              REG_W         = 16;
  localparam logic [ADDR_W-1:0] ADDR_ACQ_CFG  = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_BAL_SW   = 8'h1a;
  localparam logic [ADDR_W-1:0] ADDR_DEV_CFG2 = 8'h1b;
  localparam logic [ADDR_W-1:0] ADDR_BAL_DIAG = 8'h1c;
  localparam logic [REG_W-1:0]  REG_RESET     = 16'h0000;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int THERM_MODE_LSB = 8;
  localparam int THERM_MODE_W   = 2;
  localparam int AUX_SETTLE_LSB = 0;
  localparam int AUX_SETTLE_W   = 6;
  localparam int BAL_SW_LSB     = 0;
  localparam int BAL_SW_W       = 12;
  localparam int LOOP_BIT       = 15;
  localparam int DBLBUF_BIT     = 12;
  localparam int TXL_HIZ_BIT    = 11;
  localparam int TXU_HIZ_BIT    = 10;
  localparam int RSVD9_BIT      = 9;
  localparam int EMG_BIT        = 8;
  localparam int HVCP_BIT       = 0;
  localparam int ALTMUX_BIT     = 13;
  localparam int POLARITY_BIT   = 12;
  localparam int CELL_LSB       = 0;
  localparam int CELL_W         = 12;
  localparam int UART_PORTS     = 2;
  localparam int PORT_LOWER     = 0;
  localparam int PORT_UPPER     = 1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SETTLE_STEP_NS     = 6000;
  localparam int CLK_FREQ_MHZ       = 200;
  localparam int SETTLE_STEP_CYCLES = (SETTLE_STEP_NS * CLK_FREQ_MHZ) / 1000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    THERM_AUTO_A = 2'b00,
    THERM_AUTO_B = 2'b01,
    THERM_OFF    = 2'b10,
    THERM_ON     = 2'b11
  } abcr_therm_mode_t;

  typedef enum logic {
    SETTLE_IDLE = 1'b0,
    SETTLE_WAIT = 1'b1
  } abcr_settle_state_t;

  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wrData;
  } abcr_reg_req_t;

endpackage

// [hdl/abcr_aux_settle.sv]
// Auxiliary input settling delay before each conversion
`timescale 1ns/10ps
module abcr_aux_settle #(
  parameter int STEP_CYCLES = abcr_pkg::SETTLE_STEP_CYCLES
) (
  input  logic                              clk_sys,
  input  logic                              rst,
  input  logic                              convReq,
  input  logic [abcr_pkg::AUX_SETTLE_W-1:0] settleCode,
  output logic                              settleBusy,
  output logic                              convStart
);

  // ----------------------------------------
  // Step and cycle counters
  // ----------------------------------------
  abcr_pkg::abcr_settle_state_t       state_r, state_nxt;
  logic [abcr_pkg::AUX_SETTLE_W-1:0]  step_r, step_nxt;
  logic [31:0]                        cyc_r, cyc_nxt;
  logic                               start_r, start_nxt;

  always_comb begin
    state_nxt = state_r;
    step_nxt  = step_r;
    cyc_nxt   = cyc_r;
    start_nxt = 1'b0;
    unique case (state_r)
      abcr_pkg::SETTLE_IDLE: begin
        if (convReq) begin
          state_nxt = abcr_pkg::SETTLE_WAIT;
          step_nxt  = settleCode;
          cyc_nxt   = 32'(STEP_CYCLES - 1);
        end
      end
      abcr_pkg::SETTLE_WAIT: begin
        // Wait (code + 1) steps of one step each
        if (cyc_r != 32'h0) begin
          cyc_nxt = cyc_r - 32'h1;
        end else if (step_r != '0) begin
          step_nxt = step_r - 6'h1;
          cyc_nxt  = 32'(STEP_CYCLES - 1);
        end else begin
          state_nxt = abcr_pkg::SETTLE_IDLE;
          start_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= abcr_pkg::SETTLE_IDLE;
      step_r  <= '0;
      cyc_r   <= 32'h0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      cyc_r   <= cyc_nxt;
      start_r <= start_nxt;
    end
  end

  assign settleBusy = (state_r == abcr_pkg::SETTLE_WAIT);
  assign convStart  = start_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] elapsed_r;
  logic [31:0] expect_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      elapsed_r <= 32'h0;
      expect_r  <= 32'h0;
    end else if (convReq && !settleBusy) begin
      elapsed_r <= 32'h1;
      expect_r  <= (32'(settleCode) + 32'h1) * 32'(STEP_CYCLES);
    end else begin
      elapsed_r <= elapsed_r + 32'h1;
    end
  end

  AST_SETTLE_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    convStart |-> (elapsed_r == expect_r + 32'h1))
    else $error("Settle delay length wrong");

endmodule

// [hdl/abcr_uart_port.sv]
// UART transmit idle drive and upper-port loopback
`timescale 1ns/10ps
module abcr_uart_port (
  input  logic                           clk_sys,
  input  logic                           rst,
  input  logic [abcr_pkg::UART_PORTS-1:0] txData,
  input  logic [abcr_pkg::UART_PORTS-1:0] txActive,
  input  logic [abcr_pkg::UART_PORTS-1:0] idleHighz,
  input  logic                           loopbackEn,
  input  logic                           upperRxPin,
  output logic [abcr_pkg::UART_PORTS-1:0] txOut,
  output logic [abcr_pkg::UART_PORTS-1:0] txOe,
  output logic                           upperRxData
);

  // ----------------------------------------
  // Transmit idle behaviour per port
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < abcr_pkg::UART_PORTS; p++) begin : g_port
      logic out_r, out_nxt;
      logic oe_r, oe_nxt;

      always_comb begin
        // Idle drives zero unless high-Z idle chosen
        out_nxt = txActive[p] ? txData[p] : 1'b0;
        oe_nxt  = txActive[p] | ~idleHighz[p];
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          out_r <= 1'b0;
          oe_r  <= 1'b1;
        end else begin
          out_r <= out_nxt;
          oe_r  <= oe_nxt;
        end
      end

      assign txOut[p] = out_r;
      assign txOe[p]  = oe_r;

      AST_IDLE_HIZ: assert property (@(posedge clk_sys) disable iff (rst)
        (!txActive[p] && idleHighz[p]) |=> !txOe[p])
        else $error("Idle high-Z not honoured");
    end
  endgenerate

  // ----------------------------------------
  // Receive sync and loopback
  // ----------------------------------------
  logic rxMeta_r, rxSync_r, rx_r, rx_nxt;

  always_comb begin
    // Internal loop from upper transmitter
    rx_nxt = loopbackEn ? txData[abcr_pkg::PORT_UPPER] : rxSync_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rx_r     <= 1'b1;
    end else begin
      rxMeta_r <= upperRxPin;
      rxSync_r <= rxMeta_r;
      rx_r     <= rx_nxt;
    end
  end

  assign upperRxData = rx_r;

  AST_LOOPBACK: assert property (@(posedge clk_sys) disable iff (rst)
    loopbackEn |=> (upperRxData == $past(txData[abcr_pkg::PORT_UPPER])))
    else $error("Loopback data mismatch");

endmodule

// [hdl/abcr_config_regs.sv]
// Acquisition, balance, device and diagnostic configuration registers
`timescale 1ns/10ps
module abcr_config_regs #(
  parameter int SETTLE_STEP_CYCLES = abcr_pkg::SETTLE_STEP_CYCLES
) (
  input  logic                           clk_sys,
  input  logic                           rst,
  input  abcr_pkg::abcr_reg_req_t        regReq,
  output logic [abcr_pkg::REG_W-1:0]     regRdData,
  output logic                           regRdValid,
  input  logic                           acqActive,
  input  logic                           auxConvReq,
  output logic                           auxConvStart,
  output logic                           auxSettleBusy,
  output logic                           thermistorBiasOutput,
  output logic [abcr_pkg::BAL_SW_W-1:0]  balanceSwitchEnable,
  output logic                           emergencyDischargeEnable,
  output logic                           balanceTimeoutClear,
  output logic                           altDoubleBufferSelect,
  output logic                           hvPumpDisable,
  input  logic                           measEnWrEn,
  input  logic [abcr_pkg::CELL_W-1:0]    measEnWrData,
  output logic [abcr_pkg::CELL_W-1:0]    cellMeasureEnable,
  input  logic                           muxCfgWrEn,
  input  logic                           altMuxWrData,
  input  logic                           polarityWrData,
  output logic                           altMuxSelect,
  output logic                           polaritySelect,
  input  logic                           lowerTxData,
  input  logic                           lowerTxActive,
  input  logic                           upperTxData,
  input  logic                           upperTxActive,
  input  logic                           upperRxPin,
  output logic                           lowerTxOut,
  output logic                           lowerTxOe,
  output logic                           upperTxOut,
  output logic                           upperTxOe,
  output logic                           upperRxData,
  output logic                           upperPortLoopback
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic wrAcq, wrBal, wrDev, wrDiag;
  logic [abcr_pkg::REG_W-1:0] wd;

  assign wd     = regReq.wrData;
  assign wrAcq  = regReq.wrEn && (regReq.addr == abcr_pkg::ADDR_ACQ_CFG);
  assign wrBal  = regReq.wrEn && (regReq.addr == abcr_pkg::ADDR_BAL_SW);
  assign wrDev  = regReq.wrEn && (regReq.addr == abcr_pkg::ADDR_DEV_CFG2);
  assign wrDiag = regReq.wrEn && (regReq.addr == abcr_pkg::ADDR_BAL_DIAG);

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  logic [abcr_pkg::THERM_MODE_W-1:0] thermMode_r, thermMode_nxt;
  logic [abcr_pkg::AUX_SETTLE_W-1:0] auxSettle_r, auxSettle_nxt;
  logic [abcr_pkg::BAL_SW_W-1:0]     balEn_r, balEn_nxt;
  logic                              loop_r, loop_nxt;
  logic                              dblBuf_r, dblBuf_nxt;
  logic                              txlHiz_r, txlHiz_nxt;
  logic                              txuHiz_r, txuHiz_nxt;
  logic                              rsvd9_r, rsvd9_nxt;
  logic                              emg_r, emg_nxt;
  logic                              hvcp_r, hvcp_nxt;
  logic                              altMux_r, altMux_nxt;
  logic                              polarity_r, polarity_nxt;
  logic [abcr_pkg::CELL_W-1:0]       cell_measure_enable_r, cell_measure_enable_nxt;
  logic                              tmrClr_r, tmrClr_nxt;
  logic                              bias_r, bias_nxt;

  always_comb begin
    thermMode_nxt = thermMode_r;
    auxSettle_nxt = auxSettle_r;
    balEn_nxt     = balEn_r;
    loop_nxt      = loop_r;
    dblBuf_nxt    = dblBuf_r;
    txlHiz_nxt    = txlHiz_r;
    txuHiz_nxt    = txuHiz_r;
    rsvd9_nxt     = rsvd9_r;
    emg_nxt       = emg_r;
    hvcp_nxt      = hvcp_r;
    altMux_nxt    = altMux_r;
    polarity_nxt  = polarity_r;
    cell_measure_enable_nxt    = cell_measure_enable_r;
    if (wrAcq) begin
      thermMode_nxt = wd[abcr_pkg::THERM_MODE_LSB +: abcr_pkg::THERM_MODE_W];
      auxSettle_nxt = wd[abcr_pkg::AUX_SETTLE_LSB +: abcr_pkg::AUX_SETTLE_W];
    end
    if (wrBal) begin
      balEn_nxt = wd[abcr_pkg::BAL_SW_LSB +: abcr_pkg::BAL_SW_W];
    end
    if (wrDev) begin
      loop_nxt   = wd[abcr_pkg::LOOP_BIT];
      dblBuf_nxt = wd[abcr_pkg::DBLBUF_BIT];
      txlHiz_nxt = wd[abcr_pkg::TXL_HIZ_BIT];
      txuHiz_nxt = wd[abcr_pkg::TXU_HIZ_BIT];
      rsvd9_nxt  = wd[abcr_pkg::RSVD9_BIT];
      emg_nxt    = wd[abcr_pkg::EMG_BIT];
      hvcp_nxt   = wd[abcr_pkg::HVCP_BIT];
    end
    // Shared with other registers, bus write wins
    if (muxCfgWrEn) begin
      altMux_nxt   = altMuxWrData;
      polarity_nxt = polarityWrData;
    end
    if (measEnWrEn) begin
      cell_measure_enable_nxt = measEnWrData;
    end
    if (wrDiag) begin
      altMux_nxt   = wd[abcr_pkg::ALTMUX_BIT];
      polarity_nxt = wd[abcr_pkg::POLARITY_BIT];
      cell_measure_enable_nxt   = wd[abcr_pkg::CELL_LSB +: abcr_pkg::CELL_W];
    end
    // Clear pulse on rising discharge enable
    tmrClr_nxt = emg_nxt & ~emg_r;
    // Bias switch control
    unique case (abcr_pkg::abcr_therm_mode_t'(thermMode_nxt))
      abcr_pkg::THERM_AUTO_A: bias_nxt = acqActive;
      abcr_pkg::THERM_AUTO_B: bias_nxt = acqActive;
      abcr_pkg::THERM_OFF:    bias_nxt = 1'b0;
      abcr_pkg::THERM_ON:     bias_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // Everything clears
      thermMode_r <= '0;
      auxSettle_r <= '0;
      balEn_r     <= '0;
      loop_r      <= 1'b0;
      dblBuf_r    <= 1'b0;
      txlHiz_r    <= 1'b0;
      txuHiz_r    <= 1'b0;
      rsvd9_r     <= 1'b0;
      emg_r       <= 1'b0;
      hvcp_r      <= 1'b0;
      altMux_r    <= 1'b0;
      polarity_r  <= 1'b0;
      cell_measure_enable_r    <= '0;
      tmrClr_r    <= 1'b0;
      bias_r      <= 1'b0;
    end else begin
      thermMode_r <= thermMode_nxt;
      auxSettle_r <= auxSettle_nxt;
      balEn_r     <= balEn_nxt;
      loop_r      <= loop_nxt;
      dblBuf_r    <= dblBuf_nxt;
      txlHiz_r    <= txlHiz_nxt;
      txuHiz_r    <= txuHiz_nxt;
      rsvd9_r     <= rsvd9_nxt;
      emg_r       <= emg_nxt;
      hvcp_r      <= hvcp_nxt;
      altMux_r    <= altMux_nxt;
      polarity_r  <= polarity_nxt;
      cell_measure_enable_r    <= cell_measure_enable_nxt;
      tmrClr_r    <= tmrClr_nxt;
      bias_r      <= bias_nxt;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [abcr_pkg::REG_W-1:0] rdData_r, rdData_nxt;
  logic                       rdValid_r, rdValid_nxt;
  logic [abcr_pkg::REG_W-1:0] rdWord;

  always_comb begin
    // Unused positions and reserved positions other than bit 9 stay zero
    rdWord = abcr_pkg::REG_RESET;
    unique case (regReq.addr)
      abcr_pkg::ADDR_ACQ_CFG: begin
        rdWord[abcr_pkg::THERM_MODE_LSB +: abcr_pkg::THERM_MODE_W] = thermMode_r;
        rdWord[abcr_pkg::AUX_SETTLE_LSB +: abcr_pkg::AUX_SETTLE_W] = auxSettle_r;
      end
      abcr_pkg::ADDR_BAL_SW: begin
        rdWord[abcr_pkg::BAL_SW_LSB +: abcr_pkg::BAL_SW_W] = balEn_r;
      end
      abcr_pkg::ADDR_DEV_CFG2: begin
        rdWord[abcr_pkg::LOOP_BIT]    = loop_r;
        rdWord[abcr_pkg::DBLBUF_BIT]  = dblBuf_r;
        rdWord[abcr_pkg::TXL_HIZ_BIT] = txlHiz_r;
        rdWord[abcr_pkg::TXU_HIZ_BIT] = txuHiz_r;
        rdWord[abcr_pkg::RSVD9_BIT]   = rsvd9_r;
        rdWord[abcr_pkg::EMG_BIT]     = emg_r;
        rdWord[abcr_pkg::HVCP_BIT]    = hvcp_r;
      end
      abcr_pkg::ADDR_BAL_DIAG: begin
        rdWord[abcr_pkg::ALTMUX_BIT]   = altMux_r;
        rdWord[abcr_pkg::POLARITY_BIT] = polarity_r;
        rdWord[abcr_pkg::CELL_LSB +: abcr_pkg::CELL_W] = cell_measure_enable_r;
      end
      default: rdWord = abcr_pkg::REG_RESET;
    endcase
    rdValid_nxt = regReq.rdEn;
    rdData_nxt  = regReq.rdEn ? rdWord : rdData_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_r  <= abcr_pkg::REG_RESET;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  logic [abcr_pkg::UART_PORTS-1:0] portTxOut, portTxOe;

  abcr_aux_settle #(
    .STEP_CYCLES (SETTLE_STEP_CYCLES)
  ) u_settle (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .convReq    (auxConvReq),
    .settleCode (auxSettle_r),
    .settleBusy (auxSettleBusy),
    .convStart  (auxConvStart)
  );

  abcr_uart_port u_uart (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .txData      ({upperTxData, lowerTxData}),
    .txActive    ({upperTxActive, lowerTxActive}),
    .idleHighz   ({txuHiz_r, txlHiz_r}),
    .loopbackEn  (loop_r),
    .upperRxPin  (upperRxPin),
    .txOut       (portTxOut),
    .txOe        (portTxOe),
    .upperRxData (upperRxData)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdData                = rdData_r;
  assign regRdValid               = rdValid_r;
  assign thermistorBiasOutput     = bias_r;
  assign balanceSwitchEnable      = balEn_r;
  assign emergencyDischargeEnable = emg_r;
  assign balanceTimeoutClear      = tmrClr_r;
  assign altDoubleBufferSelect    = dblBuf_r;
  assign hvPumpDisable            = hvcp_r;
  assign cellMeasureEnable        = cell_measure_enable_r;
  assign altMuxSelect             = altMux_r;
  assign polaritySelect           = polarity_r;
  assign upperPortLoopback        = loop_r;
  assign lowerTxOut               = portTxOut[abcr_pkg::PORT_LOWER];
  assign lowerTxOe                = portTxOe[abcr_pkg::PORT_LOWER];
  assign upperTxOut               = portTxOut[abcr_pkg::PORT_UPPER];
  assign upperTxOe                = portTxOe[abcr_pkg::PORT_UPPER];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_THERM_OFF: assert property (
    (thermMode_r == abcr_pkg::THERM_OFF && !wrAcq) |=> !thermistorBiasOutput)
    else $error("Bias on in forced-off mode");

  AST_THERM_ON: assert property (
    (thermMode_r == abcr_pkg::THERM_ON && !wrAcq) |=> thermistorBiasOutput)
    else $error("Bias off in forced-on mode");

  AST_THERM_AUTO: assert property (
    (!thermMode_r[1] && !wrAcq) |=> (thermistorBiasOutput == $past(acqActive)))
    else $error("Auto bias not following acquisition");

  AST_BAL_WRITE: assert property (
    wrBal |=> (balanceSwitchEnable == $past(wd[abcr_pkg::BAL_SW_W-1:0])))
    else $error("Balance enables not written");

  AST_RSVD_ZERO: assert property (
    (regReq.rdEn && regReq.addr == abcr_pkg::ADDR_DEV_CFG2) |=> (regRdData[14:13] == 2'h0 && regRdData[7:1] == 7'h00))
    else $error("Reserved bits read nonzero");

  AST_RSVD9_ECHO: assert property (
    wrDev ##1 (regReq.rdEn && regReq.addr == abcr_pkg::ADDR_DEV_CFG2 && !wrDev)
      |=> (regRdData[abcr_pkg::RSVD9_BIT] == $past(wd[abcr_pkg::RSVD9_BIT], 2)))
    else $error("Reserved bit 9 not echoed");

  AST_EMG_CLEAR: assert property (
    $rose(emergencyDischargeEnable) |-> balanceTimeoutClear ##1 !balanceTimeoutClear)
    else $error("Balance timer not cleared on discharge enable");

  AST_CELL_MIRROR: assert property (
    (measEnWrEn && !wrDiag) |=> (cellMeasureEnable == $past(measEnWrData)))
    else $error("Cell enable mirror not updated");

  AST_MUX_MIRROR: assert property (
    wrDiag |=> (altMuxSelect == $past(wd[abcr_pkg::ALTMUX_BIT]) &&
                polaritySelect == $past(wd[abcr_pkg::POLARITY_BIT])))
    else $error("Mux mirror bits not written");

  AST_RESET_ZERO: assert property (@(posedge clk_sys) disable iff (1'b0)
    $past(rst) |-> (balanceSwitchEnable == '0 && !emergencyDischargeEnable &&
                    !hvPumpDisable && cellMeasureEnable == '0))
    else $error("Registers not zero after reset");

endmodule

// [tb/abcr_link_peer.sv]
// Upper neighbour model driving the upper receive pin
`timescale 1ns/10ps
module abcr_link_peer (
  input  wire logic clk_sys,
  input  wire logic sendEn,
  input  wire logic sendBit,
  output logic      upperRxPin
);
  logic flip;
  initial flip = 1'b0;
  always @(posedge clk_sys) flip <= ~flip;
  // Released line changes every cycle
  assign upperRxPin = sendEn ? sendBit : flip;
endmodule

// [tb/testbench.sv]
// Self-checking bench for the configuration registers
`timescale 1ns/10ps
module testbench;
  localparam int STEP = 4;
  logic clk_sys, rst, acqActive, auxConvReq, measEnWrEn, muxCfgWrEn, altMuxWrData, polarityWrData;
  logic lowerTxData, lowerTxActive, upperTxData, upperTxActive, upperRxPin, sendEn, sendBit;
  logic regRdValid, auxConvStart, auxSettleBusy, thermistorBiasOutput, emergencyDischargeEnable;
  logic balanceTimeoutClear, altDoubleBufferSelect, hvPumpDisable, altMuxSelect, polaritySelect;
  logic lowerTxOut, lowerTxOe, upperTxOut, upperTxOe, upperRxData, upperPortLoopback;
  logic [15:0] regRdData;
  logic [11:0] balanceSwitchEnable, cellMeasureEnable, measEnWrData;
  abcr_pkg::abcr_reg_req_t regReq;
  int nMismatch = 0;
  int cmpCount = 0;
  int n;
  logic [7:0] addrs[4] = '{abcr_pkg::ADDR_ACQ_CFG, abcr_pkg::ADDR_BAL_SW, abcr_pkg::ADDR_DEV_CFG2,
                           abcr_pkg::ADDR_BAL_DIAG};
  logic [15:0] masks[4] = '{16'h033f, 16'h0fff, 16'h9f01, 16'h3fff};
  logic [5:0] codes[3] = '{6'h00, 6'h05, 6'h3f};

  abcr_config_regs #(.SETTLE_STEP_CYCLES(STEP)) uut (
    .clk_sys, .rst, .regReq, .regRdData, .regRdValid, .acqActive, .auxConvReq, .auxConvStart,
    .auxSettleBusy, .thermistorBiasOutput, .balanceSwitchEnable, .emergencyDischargeEnable,
    .balanceTimeoutClear, .altDoubleBufferSelect, .hvPumpDisable, .measEnWrEn, .measEnWrData,
    .cellMeasureEnable, .muxCfgWrEn, .altMuxWrData, .polarityWrData, .altMuxSelect, .polaritySelect,
    .lowerTxData, .lowerTxActive, .upperTxData, .upperTxActive, .upperRxPin, .lowerTxOut, .lowerTxOe,
    .upperTxOut, .upperTxOe, .upperRxData, .upperPortLoopback);
  abcr_link_peer peer (.clk_sys, .sendEn, .sendBit, .upperRxPin);

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regReq.addr = a;
    regReq.wrData = d;
    regReq.wrEn = 1'b1;
    tick();
    regReq.wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    regReq.addr = a;
    regReq.rdEn = 1'b1;
    tick();
    regReq.rdEn = 1'b0;
    chk("rdValid", 16'h0001, {15'h0, regRdValid});
    chk("rdData", exp, regRdData);
  endtask
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    nMismatch++;
    closeOut();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst, sendEn} = 2'b11;
    regReq = '0;
    {acqActive, auxConvReq, measEnWrEn, muxCfgWrEn, altMuxWrData, polarityWrData, sendBit} = '0;
    {lowerTxData, lowerTxActive, upperTxData, upperTxActive, measEnWrData} = '0;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i], 16'h0000);
      tick();
    end
    rd(8'h1d, 16'h0000);
    chk("txIdle", 16'h000a, {12'h0, lowerTxOe, lowerTxOut, upperTxOe, upperTxOut});
    foreach (addrs[i]) begin
      wr(addrs[i], 16'hffff);
      rd(addrs[i], masks[i]);
    end
    chk("flags", 16'h001f, {11'h0, emergencyDischargeEnable, altDoubleBufferSelect, hvPumpDisable,
        upperPortLoopback, thermistorBiasOutput});
    chk("mirror", 16'h3fff, {2'h0, altMuxSelect, polaritySelect, cellMeasureEnable});
    wr(abcr_pkg::ADDR_BAL_SW, 16'hf005);
    chk("balSw", 16'h0005, {4'h0, balanceSwitchEnable});
    tick();
    wr(abcr_pkg::ADDR_DEV_CFG2, 16'h0200);
    rd(abcr_pkg::ADDR_DEV_CFG2, 16'h0200);
    wr(abcr_pkg::ADDR_DEV_CFG2, 16'h0100);
    chk("emgClr", 16'h0003, {14'h0, emergencyDischargeEnable, balanceTimeoutClear});
    tick();
    chk("emgClr", 16'h0002, {14'h0, emergencyDischargeEnable, balanceTimeoutClear});
    for (int m = 0; m < 4; m++) begin
      for (int a = 0; a < 2; a++) begin
        acqActive = a[0];
        wr(abcr_pkg::ADDR_ACQ_CFG, {6'h0, m[1:0], 8'h00});
        tick();
        chk("bias", {15'h0, (m[1] ? m[0] : a[0])}, {15'h0, thermistorBiasOutput});
      end
    end
    foreach (codes[i]) begin
      wr(abcr_pkg::ADDR_ACQ_CFG, {10'h0, codes[i]});
      auxConvReq = 1'b1;
      tick();
      chk("busy", 16'h0001, {15'h0, auxSettleBusy});
      n = 1;
      while (auxConvStart !== 1'b1 && n < 300) begin
        auxConvReq = (n == 2);
        tick();
        n++;
      end
      auxConvReq = 1'b0;
      chk("settle", (codes[i] + 1) * STEP + 1, n[15:0]);
      chk("busy", 16'h0000, {15'h0, auxSettleBusy});
    end
    // Host keeps pump and double-buffer bits clear
    wr(abcr_pkg::ADDR_DEV_CFG2, 16'h0c00);
    tick();
    chk("txIdle", 16'h0000, {12'h0, lowerTxOe, lowerTxOut, upperTxOe, upperTxOut});
    {lowerTxActive, lowerTxData} = 2'b11;
    tick();
    chk("txIdle", 16'h000c, {12'h0, lowerTxOe, lowerTxOut, upperTxOe, upperTxOut});
    lowerTxActive = 1'b0;
    wr(abcr_pkg::ADDR_DEV_CFG2, 16'h0800);
    tick();
    chk("txIdle", 16'h0002, {12'h0, lowerTxOe, lowerTxOut, upperTxOe, upperTxOut});
    wr(abcr_pkg::ADDR_DEV_CFG2, 16'h8000);
    {sendEn, upperTxActive, upperTxData} = 3'b010;
    tick();
    tick();
    chk("loop", 16'h0002, {14'h0, upperPortLoopback, upperRxData});
    upperTxData = 1'b1;
    tick();
    chk("loop", 16'h0003, {14'h0, upperPortLoopback, upperRxData});
    wr(abcr_pkg::ADDR_DEV_CFG2, 16'h0000);
    {sendEn, sendBit, upperTxData} = 3'b101;
    repeat (4) tick();
    chk("loop", 16'h0000, {14'h0, upperPortLoopback, upperRxData});
    measEnWrData = 12'ha5c;
    measEnWrEn = 1'b1;
    tick();
    measEnWrEn = 1'b0;
    chk("cell", 16'h0a5c, {4'h0, cellMeasureEnable});
    {altMuxWrData, polarityWrData, muxCfgWrEn} = 3'b101;
    tick();
    muxCfgWrEn = 1'b0;
    rd(abcr_pkg::ADDR_BAL_DIAG, 16'h2a5c);
    // Bus write to the mirror wins over the other writers
    measEnWrData = 12'h0f0;
    {measEnWrEn, altMuxWrData, polarityWrData, muxCfgWrEn} = 4'b1101;
    wr(abcr_pkg::ADDR_BAL_DIAG, 16'h1123);
    {measEnWrEn, muxCfgWrEn} = 2'b00;
    chk("mirror", 16'h1123, {2'h0, altMuxSelect, polaritySelect, cellMeasureEnable});
    closeOut();
  end
endmodule
